// *** include/udbt_defines.svh ***
// Constants of the double-buffered serial transmitter
`ifndef UDBT_DEFINES_SVH
`define UDBT_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define UDBT_DATA_W         8
`define UDBT_CTRL_W         5
`define UDBT_FIFO_DEPTH     4
`define UDBT_TICK_W         6
`define UDBT_BITS_W         4

// ----------------------------------------------------------------
// Control word field positions
// ----------------------------------------------------------------
`define UDBT_CTRL_LEN_LO    0
`define UDBT_CTRL_LEN_HI    1
`define UDBT_CTRL_STOP      2
`define UDBT_CTRL_PDIS      3
`define UDBT_CTRL_PSENSE    4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UDBT_LINE_MARK      1'b1
`define UDBT_STRB_IDLE      2'h3
`define UDBT_CTRL_RST       5'h0b

// ----------------------------------------------------------------
// Bit counts, and bit timing in ticks of the 16x transmitter clock
// ----------------------------------------------------------------
`define UDBT_MIN_BITS       4'h5
`define UDBT_LAST_BIT       4'h1
`define UDBT_TICK_LAST      6'h0f
`define UDBT_STOP1_TICKS    6'h10
`define UDBT_STOP15_TICKS   6'h18
`define UDBT_STOP2_TICKS    6'h20

`endif

// *** include/udbt_pkg.sv ***
// Types shared by the transmitter design
`include "udbt_defines.svh"
`default_nettype none
package udbt_pkg;

  // ----------------------------------------------------------------
  // Shifter states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } udbt_state_e;

  // ----------------------------------------------------------------
  // Complete state of the transmitter top
  // ----------------------------------------------------------------
  typedef struct packed {
    udbt_state_e                state;     // Shifter phase
    logic [`UDBT_TICK_W-1:0]    tick_cnt;  // Ticks inside current bit
    logic [`UDBT_BITS_W-1:0]    bit_cnt;   // Data bits still to send
    logic [`UDBT_DATA_W-1:0]    shift;     // Shift register
    logic                       par_bit;   // Parity of current character
    logic                       serial;    // Line level
    logic                       done;      // End of character flag
    logic [`UDBT_CTRL_W-1:0]    ctrl;      // Control holding register
    logic [`UDBT_CTRL_W-1:0]    fmt;       // Format of current character
    logic [1:0]                 tcp_sync;  // 16x clock synchroniser
    logic                       tcp_prev;  // 16x clock edge history
    logic [1:0]                 strb_sync; // Load strobe synchroniser
    logic                       strb_prev; // Load strobe edge history
    logic [1:0]                 cs_sync;   // Control strobe synchroniser
    logic [1:0]                 mr_sync;   // Master reset synchroniser
    logic [1:0]                 swe_sync;  // Status enable synchroniser
    logic [1:0]                 rde_sync;  // Data enable synchroniser
    logic [`UDBT_DATA_W-1:0]    d_s1;      // Data pins, first stage
    logic [`UDBT_DATA_W-1:0]    d_s2;      // Data pins, second stage
    logic [`UDBT_CTRL_W-1:0]    c_s1;      // Control pins, first stage
    logic [`UDBT_CTRL_W-1:0]    c_s2;      // Control pins, second stage
  } udbt_tx_s;

endpackage
`default_nettype wire

// *** rtl/udbt_fifo.sv ***
// Small shifting FIFO whose head word sits in a register
`default_nettype none
module udbt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  // Filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;   // Word 0 is the head
    logic [CNT_W-1:0]            count; // Words held
  } udbt_fifo_s;

  udbt_fifo_s fifo_reg;   // Registered state
  udbt_fifo_s fifo_next;  // Next state
  logic       push;       // Word accepted
  logic       pop;        // Word delivered

  // Honest flags straight from the count
  assign in_ready_out  = (fifo_reg.count != CNT_W'(DEPTH));
  assign out_valid_out = (fifo_reg.count != '0);
  assign out_data_out  = fifo_reg.mem[0];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Shifting keeps the head in one fixed register, costing a move per pop
  always_comb begin
    fifo_next = fifo_reg;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        fifo_next.mem[i] = fifo_reg.mem[i+1];
      end
    end
    if (push) begin
      fifo_next.mem[fifo_reg.count - CNT_W'(pop)] = in_data_in;
    end
    fifo_next.count = fifo_reg.count + CNT_W'(push) - CNT_W'(pop);
  end

  // Register the state
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

endmodule
`default_nettype wire

// *** rtl/udbt_tx.sv ***
// Double-buffered asynchronous serial transmitter with parallel load pins
`include "udbt_defines.svh"
`default_nettype none
module udbt_tx
  import udbt_pkg::*;
#(
  parameter int FIFO_DEPTH = `UDBT_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    sys_rst_in,
  // Master reset and transmitter clock pins
  input  wire logic                    master_reset_in,
  input  wire logic                    tx_clock_16x_in,
  // Data load pins
  input  wire logic                    tx_load_strobe_n_in,
  input  wire logic [`UDBT_DATA_W-1:0] tx_data_in,
  output logic                         tx_fifo_ready_out,
  // Format control pins
  input  wire logic                    control_strobe_in,
  input  wire logic                    length_select_lo_in,
  input  wire logic                    length_select_hi_in,
  input  wire logic                    stop_count_select_in,
  input  wire logic                    parity_disable_in,
  input  wire logic                    parity_sense_in,
  // Output enable pins
  input  wire logic                    status_output_enable_n_in,
  input  wire logic                    rx_data_output_enable_n_in,
  // Serial line and status
  output logic                         tx_serial_out,
  output logic                         tx_char_done_out,
  output logic                         tx_holding_empty_out,
  output logic                         tx_holding_empty_oe_n_out,
  output logic                         rx_data_oe_n_out
);

  import udbt_pkg::*;

  // ----------------------------------------------------------------
  // Format decoding helpers
  // ----------------------------------------------------------------

  // Number of data bits for a control word
  function automatic logic [`UDBT_BITS_W-1:0] data_bits(input logic [`UDBT_CTRL_W-1:0] c);
    data_bits = `UDBT_MIN_BITS + {2'h0, c[`UDBT_CTRL_LEN_HI], c[`UDBT_CTRL_LEN_LO]};
  endfunction

  // Length of the stop period in ticks
  function automatic logic [`UDBT_TICK_W-1:0] stop_ticks(input logic [`UDBT_CTRL_W-1:0] c);
    if (!c[`UDBT_CTRL_STOP]) begin
      stop_ticks = `UDBT_STOP1_TICKS;
    end else if (data_bits(c) == `UDBT_MIN_BITS) begin
      stop_ticks = `UDBT_STOP15_TICKS;
    end else begin
      stop_ticks = `UDBT_STOP2_TICKS;
    end
  endfunction

  // Parity bit over the selected data bits only
  function automatic logic parity_of(input logic [`UDBT_DATA_W-1:0] d,
                                     input logic [`UDBT_CTRL_W-1:0] c);
    logic [`UDBT_DATA_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < `UDBT_DATA_W; i++) begin
      mask[i] = (i < int'(data_bits(c)));
    end
    // Sense low asks for odd parity, high for even
    parity_of = (^(d & mask)) ^ ~c[`UDBT_CTRL_PSENSE];
  endfunction

  // ----------------------------------------------------------------
  // State and glue
  // ----------------------------------------------------------------
  udbt_tx_s                tx_reg;     // Registered state
  udbt_tx_s                tx_next;    // Next state
  logic                    tick;       // One 16x clock rising edge
  logic                    strb_edge;  // Trailing edge of load strobe
  logic                    mr_active;  // Synchronised master reset
  logic                    fifo_rst;   // Flush of the holding buffer
  logic                    fifo_valid; // Holding buffer has a word
  logic                    fifo_pop;   // Shifter takes a word
  logic [`UDBT_DATA_W-1:0] fifo_data;  // Head word of the buffer
  logic                    bit_end;    // Last tick of a normal bit
  logic                    stop_end;   // Last tick of the stop period

  assign tick      = tx_reg.tcp_sync[1] & ~tx_reg.tcp_prev;
  assign strb_edge = tx_reg.strb_sync[1] & ~tx_reg.strb_prev;
  assign mr_active = tx_reg.mr_sync[1];
  assign fifo_rst  = sys_rst_in | mr_active;
  assign bit_end   = tick & (tx_reg.tick_cnt == `UDBT_TICK_LAST);
  assign stop_end  = tick & (tx_reg.tick_cnt == stop_ticks(tx_reg.fmt) - `UDBT_TICK_W'(1));
  // Shifter drains only when idle, so the buffer fills while it is busy
  assign fifo_pop  = fifo_valid & (tx_reg.state == ST_IDLE) & ~mr_active;

  // ----------------------------------------------------------------
  // Holding buffer
  // ----------------------------------------------------------------
  // A strobe while full is dropped; tx_fifo_ready_out warns the host
  udbt_fifo #(
    .WIDTH (`UDBT_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .rst_in        (fifo_rst),
    .in_valid_in   (strb_edge),
    .in_ready_out  (tx_fifo_ready_out),
    .in_data_in    (tx_reg.d_s2),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tx_serial_out             = tx_reg.serial;
  assign tx_char_done_out          = tx_reg.done;
  assign tx_holding_empty_out      = ~fifo_valid;
  // Enables pass through unchanged; low means the output drives
  assign tx_holding_empty_oe_n_out = tx_reg.swe_sync[1];
  assign rx_data_oe_n_out          = tx_reg.rde_sync[1];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    tx_next = tx_reg;
    // Pin synchronisers; only the second stage is read
    tx_next.tcp_sync  = {tx_reg.tcp_sync[0], tx_clock_16x_in};
    tx_next.tcp_prev  = tx_reg.tcp_sync[1];
    tx_next.strb_sync = {tx_reg.strb_sync[0], tx_load_strobe_n_in};
    tx_next.strb_prev = tx_reg.strb_sync[1];
    tx_next.cs_sync   = {tx_reg.cs_sync[0], control_strobe_in};
    tx_next.mr_sync   = {tx_reg.mr_sync[0], master_reset_in};
    tx_next.swe_sync  = {tx_reg.swe_sync[0], status_output_enable_n_in};
    tx_next.rde_sync  = {tx_reg.rde_sync[0], rx_data_output_enable_n_in};
    tx_next.d_s1      = tx_data_in;
    tx_next.d_s2      = tx_reg.d_s1;
    tx_next.c_s1      = {parity_sense_in, parity_disable_in, stop_count_select_in,
                         length_select_hi_in, length_select_lo_in};
    tx_next.c_s2      = tx_reg.c_s1;

    // Level-sensitive capture, independent of the data strobe
    if (tx_reg.cs_sync[1]) begin
      tx_next.ctrl = tx_reg.c_s2;
    end

    // Ticks come only from the transmitter's own 16x clock
    if (tick) begin
      tx_next.tick_cnt = tx_reg.tick_cnt + `UDBT_TICK_W'(1);
    end

    unique case (tx_reg.state)
      ST_IDLE: begin
        // Take the buffer at once and open with the start bit
        if (fifo_pop) begin
          tx_next.state    = ST_START;
          tx_next.shift    = fifo_data;
          tx_next.fmt      = tx_reg.ctrl;
          tx_next.bit_cnt  = data_bits(tx_reg.ctrl);
          tx_next.par_bit  = parity_of(fifo_data, tx_reg.ctrl);
          tx_next.serial   = 1'b0;
          tx_next.done     = 1'b0;
          tx_next.tick_cnt = '0;
        end
      end
      ST_START: begin
        // Least significant bit follows the start bit
        if (bit_end) begin
          tx_next.state    = ST_DATA;
          tx_next.serial   = tx_reg.shift[0];
          tx_next.tick_cnt = '0;
        end
      end
      ST_DATA: begin
        if (bit_end) begin
          tx_next.tick_cnt = '0;
          if (tx_reg.bit_cnt != `UDBT_LAST_BIT) begin
            // More data bits to go
            tx_next.shift   = tx_reg.shift >> 1;
            tx_next.serial  = tx_reg.shift[1];
            tx_next.bit_cnt = tx_reg.bit_cnt - `UDBT_BITS_W'(1);
          end else if (tx_reg.fmt[`UDBT_CTRL_PDIS]) begin
            // No parity: stop bits follow the last data bit
            tx_next.state  = ST_STOP;
            tx_next.serial = `UDBT_LINE_MARK;
          end else begin
            tx_next.state  = ST_PARITY;
            tx_next.serial = tx_reg.par_bit;
          end
        end
      end
      ST_PARITY: begin
        if (bit_end) begin
          tx_next.state    = ST_STOP;
          tx_next.serial   = `UDBT_LINE_MARK;
          tx_next.tick_cnt = '0;
        end
      end
      ST_STOP: begin
        // Done rises after the whole stop period; idle reloads next cycle
        if (stop_end) begin
          tx_next.state    = ST_IDLE;
          tx_next.done     = 1'b1;
          tx_next.tick_cnt = '0;
        end
      end
      default: begin
        // Unused code: recover to a resting line
        tx_next.state  = ST_IDLE;
        tx_next.serial = `UDBT_LINE_MARK;
        tx_next.done   = 1'b1;
      end
    endcase

    // Master reset pin aborts any character, line back to mark
    if (mr_active) begin
      tx_next.state    = ST_IDLE;
      tx_next.serial   = `UDBT_LINE_MARK;
      tx_next.done     = 1'b1;
      tx_next.tick_cnt = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Strobe history resets high so release makes no false load edge
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_reg           <= '0;
      tx_reg.serial    <= `UDBT_LINE_MARK;
      tx_reg.done      <= 1'b1;
      tx_reg.ctrl      <= `UDBT_CTRL_RST;
      tx_reg.fmt       <= `UDBT_CTRL_RST;
      tx_reg.strb_sync <= `UDBT_STRB_IDLE;
      tx_reg.strb_prev <= 1'b1;
      tx_reg.swe_sync  <= `UDBT_STRB_IDLE;
      tx_reg.rde_sync  <= `UDBT_STRB_IDLE;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in || mr_active);

  sequence s_idle_load;
    (tx_reg.state == ST_IDLE) && fifo_valid;
  endsequence

  sequence s_start_bit;
    (tx_reg.state == ST_START) && !tx_serial_out && !tx_char_done_out;
  endsequence

  a_reset_marking: assert property (disable iff (1'b0)
    sys_rst_in |=> (tx_serial_out && tx_char_done_out && tx_holding_empty_out))
    else $error("line or flags not high after reset");

  a_load_fills: assert property (
    (strb_edge && tx_fifo_ready_out) |=> !tx_holding_empty_out)
    else $error("load strobe did not fill buffer");

  a_busy_holds: assert property (
    (tx_reg.state != ST_IDLE && !tx_holding_empty_out) |=> !tx_holding_empty_out)
    else $error("buffer emptied while shifter busy");

  a_idle_start: assert property (
    s_idle_load |=> s_start_bit)
    else $error("idle shifter did not start character");

  a_start_latency: assert property (
    (strb_edge && tx_fifo_ready_out && tx_holding_empty_out && tx_reg.state == ST_IDLE)
    |-> ##[1:3] !tx_serial_out)
    else $error("start bit late after load strobe");

  a_start_length: assert property (
    (bit_end && tx_reg.state == ST_START) |=> (tx_reg.state == ST_DATA && tx_reg.tick_cnt == '0))
    else $error("start bit not followed by data");

  a_parity_skip: assert property (
    (bit_end && tx_reg.state == ST_DATA && tx_reg.bit_cnt == `UDBT_LAST_BIT)
    |=> (tx_reg.state == (tx_reg.fmt[`UDBT_CTRL_PDIS] ? ST_STOP : ST_PARITY)))
    else $error("parity phase wrong for mode");

  a_stop_mark: assert property (
    (tx_reg.state == ST_STOP) |-> tx_serial_out)
    else $error("line not marking during stop");

  a_done_rise: assert property (
    (stop_end && tx_reg.state == ST_STOP) |=> (tx_char_done_out && tx_reg.state == ST_IDLE))
    else $error("end of character not raised");

  a_ctrl_capture: assert property (
    tx_reg.cs_sync[1] |=> (tx_reg.ctrl == $past(tx_reg.c_s2)))
    else $error("control word not captured");

  a_status_oe: assert property (
    tx_holding_empty_oe_n_out == $past(tx_reg.swe_sync[0]))
    else $error("status enable not followed");

  a_next_start: assert property (
    (stop_end && tx_reg.state == ST_STOP && fifo_valid) |=> ##1 s_start_bit)
    else $error("waiting character did not follow");

  a_len_short: assert property (
    (fifo_pop && ~|tx_reg.ctrl[`UDBT_CTRL_LEN_HI:`UDBT_CTRL_LEN_LO]) |=> (tx_reg.bit_cnt == `UDBT_MIN_BITS))
    else $error("short length not decoded");

  a_len_full: assert property (
    (fifo_pop && &tx_reg.ctrl[`UDBT_CTRL_LEN_HI:`UDBT_CTRL_LEN_LO])
    |=> (tx_reg.bit_cnt == `UDBT_BITS_W'(`UDBT_DATA_W)))
    else $error("full length not decoded");

  a_stop_min: assert property (
    (tx_reg.state == ST_STOP && tx_reg.tick_cnt < `UDBT_TICK_LAST) |=> (tx_reg.state == ST_STOP))
    else $error("stop period cut short");

  a_idle_mark: assert property (
    (tx_reg.state == ST_IDLE) |-> tx_serial_out)
    else $error("line not marking while idle");

endmodule
`default_nettype wire

// *** dv/udbt_host_model.sv ***
// Host side model: 16x clock, master reset, format and load pins
`default_nettype none
module udbt_host_model (
  // Clock
  input  wire logic       clock_in,
  // Pins toward the transmitter
  output var logic        master_reset_out,
  output var logic        tx_clock_16x_out,
  output var logic        tx_load_strobe_n_out,
  output var logic [7:0]  tx_data_out,
  output var logic        control_strobe_out,
  output var logic [4:0]  ctrl_out,
  output var logic        swe_n_out,
  output var logic        rde_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg = 2'h0; // Divider for the 16x clock
  // Idle pin levels from time zero
  initial begin
    master_reset_out = 1'b0;
    tx_clock_16x_out = 1'b0;
    tx_load_strobe_n_out = 1'b1;
    tx_data_out = 8'h00;
    control_strobe_out = 1'b0;
    ctrl_out = 5'h0b;
    swe_n_out = 1'b1;
    rde_n_out = 1'b1;
  end
  // Free running 16x clock, four clocks per phase, so one bit is 128 clocks
  always @(negedge clock_in) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) tx_clock_16x_out <= ~tx_clock_16x_out;
  end
  // One strobe of the data pins, control strobe alongside when asked
  task automatic load(input logic [4:0] c, input logic use_c, input logic [7:0] d);
    @(negedge clock_in);
    ctrl_out = c;
    tx_data_out = d;
    control_strobe_out = use_c;
    tx_load_strobe_n_out = 1'b0;
    repeat (4) @(negedge clock_in);
    tx_load_strobe_n_out = 1'b1;
    control_strobe_out = 1'b0;
    repeat (4) @(negedge clock_in);
    // Released data lines must not look like the last word
    tx_data_out = ~d;
  endtask
  // Master reset pulse of n clocks
  task automatic pulse_mr(input int n);
    @(negedge clock_in);
    master_reset_out = 1'b1;
    repeat (n) @(negedge clock_in);
    master_reset_out = 1'b0;
  endtask
  // Output enable pins
  task automatic set_oe(input logic s, input logic r);
    @(negedge clock_in);
    swe_n_out = s;
    rde_n_out = r;
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the double-buffered serial transmitter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;            // System clock
  logic sys_rst_in = 1'b1;          // Synchronous reset
  wire logic mr, tck, strb_n, cs, swe_n, rde_n;
  wire logic [7:0] tdata;           // Data pins
  wire logic [4:0] ctl;             // Format pins
  wire logic rdy, ser, done, empty, swe_oe_n, rde_oe_n;
  int bad_count = 0;                // Mismatches
  int total_checks = 0;             // Comparisons
  logic [4:0] fmts [6] = '{5'h00, 5'h15, 5'h0a, 5'h07, 5'h14, 5'h0b}; // Formats
  always #5 clock_in = ~clock_in;
  udbt_host_model udbt_host_model_inst (.clock_in(clock_in), .master_reset_out(mr),
    .tx_clock_16x_out(tck), .tx_load_strobe_n_out(strb_n), .tx_data_out(tdata),
    .control_strobe_out(cs), .ctrl_out(ctl), .swe_n_out(swe_n), .rde_n_out(rde_n));
  udbt_tx udbt_tx_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .master_reset_in(mr),
    .tx_clock_16x_in(tck), .tx_load_strobe_n_in(strb_n), .tx_data_in(tdata),
    .tx_fifo_ready_out(rdy), .control_strobe_in(cs), .length_select_lo_in(ctl[0]),
    .length_select_hi_in(ctl[1]), .stop_count_select_in(ctl[2]), .parity_disable_in(ctl[3]),
    .parity_sense_in(ctl[4]), .status_output_enable_n_in(swe_n),
    .rx_data_output_enable_n_in(rde_n), .tx_serial_out(ser), .tx_char_done_out(done),
    .tx_holding_empty_out(empty), .tx_holding_empty_oe_n_out(swe_oe_n),
    .rx_data_oe_n_out(rde_oe_n));
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One comparison
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (exp !== got) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for line (0), done (1) or empty (2) to reach a level
  task automatic wait_sig(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while ((s == 0 ? ser : s == 1 ? done : empty) !== v) begin
      @(negedge clock_in);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("[ERR] wait %0d expected %b seen timeout", s, v);
        disable run_all;
      end
    end
  endtask
  // Decode one character mid-bit and check its framing
  task automatic rx(input logic [7:0] d, input logic [4:0] c, input logic e);
    int nb;
    int st;
    nb = 5 + int'(c[1:0]);
    st = c[2] ? (nb == 5 ? 24 : 32) : 16;
    wait_sig(0, 1'b0, 8);
    repeat (64) @(negedge clock_in);
    chk("start bit", 8'h0, ser);
    chk("done low", 8'h0, done);
    for (int i = 0; i < nb; i++) begin
      repeat (128) @(negedge clock_in);
      chk("data bit", d[i], ser);
    end
    if (!c[3]) begin
      repeat (128) @(negedge clock_in);
      chk("parity", ^(d & ~(8'hff << nb)) ^ !c[4], ser);
    end
    repeat (128) @(negedge clock_in);
    chk("stop bit", 8'h1, ser);
    chk("empty", e, empty);
    repeat (st * 8 - 80) @(negedge clock_in);
    chk("late stop", 8'h1, ser);
    chk("done early", 8'h0, done);
    wait_sig(1, 1'b1, 30);
  endtask
  // Main sequence; a timed-out wait leaves run_all early but still reaches the verdict
  initial begin
    begin : run_all
      udbt_host_model_inst.pulse_mr(6);
      repeat (12) @(negedge clock_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clock_in);
      chk("line idle", 8'h1, ser);
      chk("done idle", 8'h1, done);
      chk("empty idle", 8'h1, empty);
      chk("ready idle", 8'h1, rdy);
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
        udbt_host_model_inst.set_oe(i[0], !i[0]);
        repeat (4) @(negedge clock_in);
        chk("status oe", i[0], swe_oe_n);
        chk("data oe", !i[0], rde_oe_n);
      end
      $display("test enables done");
      foreach (fmts[i]) begin
        udbt_host_model_inst.load(fmts[i], 1'b1, 8'h9c + 8'(i * 53));
        rx(8'h9c + 8'(i * 53), fmts[i], 1'b1);
      end
      $display("test formats done");
      udbt_host_model_inst.load(5'h08, 1'b1, 8'he0);
      for (int k = 1; k < 5; k++) udbt_host_model_inst.load(5'h08, 1'b0, 8'he0 | 8'(k));
      chk("ready full", 8'h0, rdy);
      chk("empty full", 8'h0, empty);
      // All-zero word: if it were wrongly taken, its data bits would space the line
      udbt_host_model_inst.load(5'h08, 1'b0, 8'h00);
      wait_sig(1, 1'b1, 2000);
      for (int k = 1; k < 5; k++) rx(8'he0 | 8'(k), 5'h08, k == 4);
      repeat (400) @(negedge clock_in);
      chk("dropped word", 8'h1, ser);
      chk("rest done", 8'h1, done);
      $display("test buffer done");
      udbt_host_model_inst.load(5'h0b, 1'b1, 8'h55);
      udbt_host_model_inst.load(5'h0b, 1'b0, 8'haa);
      repeat (300) @(negedge clock_in);
      udbt_host_model_inst.pulse_mr(6);
      repeat (4) @(negedge clock_in);
      chk("mr line", 8'h1, ser);
      chk("mr done", 8'h1, done);
      chk("mr empty", 8'h1, empty);
      repeat (400) @(negedge clock_in);
      chk("mr flush", 8'h1, ser);
      $display("test master reset done");
    end
    summarize();
  end
endmodule
`default_nettype wire
